/* byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wrPtr_r;
  logic [PW-1:0]    rdPtr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  assign inReady  = count_r != (PW+1)'(DEPTH);
  assign outValid = count_r != '0;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem_r[rdPtr_r];

  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wrPtr_r] <= inData;
  end

  // depth must be a power of two so the pointers wrap by themselves
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_r + PW'(push);
      rdPtr_r <= rdPtr_r + PW'(pop);
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

/* flash_pkg.sv */
package flash_pkg;

  // command opcodes
  localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OP_PAGE_PROG        = 8'h02;
  localparam logic [7:0] OP_READ_DATA        = 8'h03;
  localparam logic [7:0] OP_WRITE_DISABLE    = 8'h04;
  localparam logic [7:0] OP_READ_STATUS      = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE     = 8'h06;
  localparam logic [7:0] OP_SECTOR_ERASE     = 8'h20;
  localparam logic [7:0] OP_QUAD_PROG        = 8'h32;
  localparam logic [7:0] OP_BLOCK32_ERASE    = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE    = 8'hD8;

  // address map
  localparam logic [23:0] TOP_ADDR_512K  = 24'h00FFFF;
  localparam logic [23:0] TOP_ADDR_4M    = 24'h07FFFF;
  localparam logic [31:0] BLOCK64_BYTES  = 32'h0001_0000;
  localparam int          SECTOR_LSB     = 12;
  localparam int          BLOCK32_LSB    = 15;
  localparam int          BLOCK64_LSB    = 16;
  localparam logic [2:0]  ADDR_BYTES     = 3'h3;
  localparam logic [2:0]  QUAD_DATA_IDX  = 3'h4;

  // status register layout
  localparam int         STAT_BUSY_BIT  = 0;
  localparam int         STAT_LATCH_BIT = 1;
  localparam int         STAT_BP_LSB    = 2;
  localparam int         STAT_QUAD_BIT  = 6;
  localparam int         STAT_LOCK_BIT  = 7;
  localparam logic [7:0] STATUS_RESET   = 8'h00;

  // timing: status write cycle length, rounded up to whole clocks
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          BUSY_TIME_NS  = 10000;
  localparam logic [15:0] BUSY_CYCLES   =
    16'((BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int FIFO_DEPTH = 4;

  typedef struct packed {
    logic       statusWriteLock;
    logic       quadLaneEnable;
    logic [3:0] protectSel;
    logic       writeEnableLatch;
    logic       busyFlag;
  } status_t;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic [11:0] sector;
    logic [11:0] offset;
    logic [8:0]  block32;
    logic [7:0]  block64;
    logic        inRange;
    logic        isProtected;
  } addr_info_t;

endpackage

/* flash_spi_front.sv */
`timescale 1ns/1ps
module flash_spi_front #(
  parameter logic [23:0] TopAddr = flash_pkg::TOP_ADDR_4M
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 sck,
  input  wire logic                 cs_n,
  input  wire logic                 lane0In,
  output logic                      lane0Out,
  output logic                      lane0Oe,
  input  wire logic                 lane1In,
  output logic                      lane1Out,
  output logic                      lane1Oe,
  input  wire logic                 lane2In,
  output logic                      lane2Out,
  output logic                      lane2Oe,
  input  wire logic                 lane3In,
  output logic                      lane3Out,
  output logic                      lane3Oe,
  output flash_pkg::status_t        statusOut,
  output logic                      addrStrobe,
  output flash_pkg::addr_info_t     addrInfo,
  output logic                      rxOverflow
);
  import flash_pkg::*;

  localparam bit Has64kBlocks = TopAddr > TOP_ADDR_512K;

  ////////////////////////////////////////////////////////////////////////////
  // link side, clocked by the serial clock

  logic       linkClr;
  logic [2:0] bitCnt_r;
  logic [7:0] shift_r;
  logic [2:0] byteIdx_r;
  logic [7:0] cmd_r;
  rx_byte_t   linkByte_r;
  logic       linkTog_r;
  logic       reqS1_r;
  logic       reqS2_r;
  logic       ackTog_r;
  status_t    linkStatus_r;
  logic [7:0] txSh_r;
  logic [2:0] txBit_r;
  logic       txOut_r;
  logic       txOe_r;
  logic       pauseActive;
  logic       quadPhase;
  logic [7:0] newByte;
  logic       byteDone;
  logic [2:0] bitCnt_nxt;
  logic       readingStatus;
  logic       pubReq_r;
  status_t    pubWord_r;

  // deselect clears the frame state; also cleared by the system reset
  assign linkClr       = cs_n || !rst_n;
  assign pauseActive   = !linkStatus_r.quadLaneEnable && !lane3In;
  assign quadPhase     = linkStatus_r.quadLaneEnable && cmd_r == OP_QUAD_PROG
                         && byteIdx_r >= QUAD_DATA_IDX;
  assign newByte       = quadPhase ? {shift_r[3:0], lane3In, lane2In, lane1In, lane0In}
                                   : {shift_r[6:0], lane0In};
  assign bitCnt_nxt    = quadPhase ? bitCnt_r + 3'h4 : bitCnt_r + 3'h1;
  assign byteDone      = !pauseActive && bitCnt_nxt == 3'h0;
  assign readingStatus = cmd_r == OP_READ_STATUS && byteIdx_r != 3'h0 && !pauseActive;

  // only rising edges are counted, so mode 0 and mode 3 behave alike
  always_ff @(posedge sck or posedge linkClr)
  begin
    if (linkClr)
    begin
      bitCnt_r  <= '0;
      shift_r   <= '0;
      byteIdx_r <= '0;
      cmd_r     <= '0;
    end
    else if (!pauseActive)
    begin
      bitCnt_r <= bitCnt_nxt;
      shift_r  <= newByte;
      if (byteDone && byteIdx_r != 3'h7)
        byteIdx_r <= byteIdx_r + 3'h1;
      if (byteDone && byteIdx_r == 3'h0)
        cmd_r <= newByte;
    end
  end

  // survives deselect: a reset here would fake a toggle to the system side
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      linkByte_r   <= '0;
      linkTog_r    <= 1'b0;
      reqS1_r      <= 1'b0;
      reqS2_r      <= 1'b0;
      ackTog_r     <= 1'b0;
      linkStatus_r <= '0;
    end
    else
    begin
      reqS1_r <= pubReq_r;
      reqS2_r <= reqS1_r;
      if (byteDone && !cs_n)
      begin
        linkByte_r <= '{first: byteIdx_r == 3'h0, data: newByte};
        linkTog_r  <= !linkTog_r;
      end
      if (reqS2_r != ackTog_r)
      begin
        linkStatus_r <= pubWord_r;
        ackTog_r     <= reqS2_r;
      end
    end
  end

  // status bytes repeat for as long as the master keeps clocking
  always_ff @(negedge sck or posedge linkClr)
  begin
    if (linkClr)
    begin
      txSh_r  <= '0;
      txBit_r <= '0;
      txOut_r <= 1'b0;
      txOe_r  <= 1'b0;
    end
    else
    begin
      txOe_r <= readingStatus;
      if (readingStatus)
      begin
        txBit_r <= txBit_r + 3'h1;
        txOut_r <= (txBit_r == 3'h0) ? linkStatus_r[7] : txSh_r[7];
        txSh_r  <= (txBit_r == 3'h0) ? {linkStatus_r[6:0], 1'b0} : {txSh_r[6:0], 1'b0};
      end
    end
  end

  assign lane1Out = txOut_r;
  assign lane1Oe  = txOe_r && !cs_n;
  assign lane0Out = 1'b0;
  assign lane0Oe  = 1'b0;
  assign lane2Out = 1'b0;
  assign lane2Oe  = 1'b0;
  assign lane3Out = 1'b0;
  assign lane3Oe  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // system side

  typedef enum logic [1:0] {ST_CMD, ST_ADDR, ST_STATUS_DATA, ST_IGNORE} proc_state_t;

  logic        rstS1_r;
  logic        rstN;
  logic        togS1_r;
  logic        togS2_r;
  logic        togS3_r;
  logic        wpS1_r;
  logic        wpSync_r;
  logic        ackS1_r;
  logic        ackS2_r;
  logic        pending_r;
  rx_byte_t    pendByte_r;
  logic        overflow_r;
  status_t     status_r;
  logic [15:0] busyCnt_r;
  proc_state_t state_r;
  logic [23:0] addr_r;
  logic [1:0]  addrCnt_r;
  logic        addrStb_r;
  addr_info_t  addrInfo_r;
  logic        byteEvent;
  logic        fifoInReady;
  logic        popValid;
  rx_byte_t    popByte;
  logic        popFire;
  logic        statusLocked;
  logic        statusWriteOk;
  logic        busyDone;
  logic [23:0] addrNxt;
  logic [31:0] protBytes;
  logic [31:0] protBase;
  addr_info_t  addrDecode;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstS1_r <= 1'b0;
      rstN    <= 1'b0;
    end
    else
    begin
      rstS1_r <= 1'b1;
      rstN    <= rstS1_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      togS1_r  <= 1'b0;
      togS2_r  <= 1'b0;
      togS3_r  <= 1'b0;
      wpS1_r   <= 1'b0;
      wpSync_r <= 1'b0;
      ackS1_r  <= 1'b0;
      ackS2_r  <= 1'b0;
    end
    else
    begin
      togS1_r  <= linkTog_r;
      togS2_r  <= togS1_r;
      togS3_r  <= togS2_r;
      wpS1_r   <= lane2In;
      wpSync_r <= wpS1_r;
      ackS1_r  <= ackTog_r;
      ackS2_r  <= ackS1_r;
    end
  end

  // the byte holder is stable for at least two serial clocks after the toggle
  assign byteEvent = togS2_r ^ togS3_r;

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      pending_r  <= 1'b0;
      pendByte_r <= '0;
      overflow_r <= 1'b0;
      pubReq_r   <= 1'b0;
      pubWord_r  <= '0;
    end
    else
    begin
      if (byteEvent)
        pendByte_r <= linkByte_r;
      pending_r  <= byteEvent || (pending_r && !fifoInReady);
      overflow_r <= overflow_r || (byteEvent && pending_r && !fifoInReady);
      if (ackS2_r == pubReq_r && status_r != pubWord_r)
      begin
        pubWord_r <= status_r;
        pubReq_r  <= !pubReq_r;
      end
    end
  end

  // the processor stalls while busy, so a long write backs up into the queue
  byte_fifo #(
    .WIDTH ($bits(rx_byte_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk      (clk_sys),
    .rstN     (rstN),
    .inData   (pendByte_r),
    .inValid  (pending_r),
    .inReady  (fifoInReady),
    .outData  (popByte),
    .outValid (popValid),
    .outReady (!status_r.busyFlag)
  );

  assign popFire       = popValid && !status_r.busyFlag;
  // quad mode takes the write-protect pin away, so it cannot lock
  assign statusLocked  = status_r.statusWriteLock && !wpSync_r
                         && !status_r.quadLaneEnable;
  assign statusWriteOk = popFire && !popByte.first && state_r == ST_STATUS_DATA
                         && status_r.writeEnableLatch && !statusLocked;
  assign busyDone      = status_r.busyFlag && busyCnt_r == 16'h0000;

  // address decode and protected window from the block-protect field
  assign addrNxt    = {addr_r[15:0], popByte.data};
  assign protBytes  = (status_r.protectSel == 4'h0) ? 32'h0 :
                      (BLOCK64_BYTES << (status_r.protectSel - 4'h1));
  assign protBase   = (protBytes > {8'h00, TopAddr} + 32'h1) ? 32'h0 :
                      {8'h00, TopAddr} + 32'h1 - protBytes;
  assign addrDecode = '{
    sector:      addrNxt[23:SECTOR_LSB],
    offset:      addrNxt[SECTOR_LSB-1:0],
    block32:     addrNxt[23:BLOCK32_LSB],
    block64:     Has64kBlocks ? addrNxt[23:BLOCK64_LSB] : 8'h00,
    inRange:     addrNxt <= TopAddr,
    isProtected: protBytes != 32'h0 && {8'h00, addrNxt} >= protBase
  };

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      status_r  <= status_t'(STATUS_RESET);
      busyCnt_r <= '0;
    end
    else
    begin
      if (statusWriteOk)
      begin
        status_r[7:STAT_BP_LSB] <= popByte.data[7:STAT_BP_LSB];
        status_r.busyFlag       <= 1'b1;
        busyCnt_r               <= BUSY_CYCLES - 16'h1;
      end
      else if (busyDone)
      begin
        status_r.busyFlag         <= 1'b0;
        status_r.writeEnableLatch <= 1'b0;
      end
      else if (status_r.busyFlag)
        busyCnt_r <= busyCnt_r - 16'h1;
      else if (popFire && popByte.first && popByte.data == OP_WRITE_ENABLE)
        status_r.writeEnableLatch <= 1'b1;
      else if (popFire && popByte.first && popByte.data == OP_WRITE_DISABLE)
        status_r.writeEnableLatch <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstN)
  begin
    if (!rstN)
    begin
      state_r    <= ST_CMD;
      addr_r     <= '0;
      addrCnt_r  <= '0;
      addrStb_r  <= 1'b0;
      addrInfo_r <= '0;
    end
    else
    begin
      addrStb_r <= 1'b0;
      if (popFire && popByte.first)
      begin
        addrCnt_r <= '0;
        case (popByte.data)
          OP_STATUS_WRITE_CMD: state_r <= ST_STATUS_DATA;
          OP_READ_DATA, OP_PAGE_PROG, OP_QUAD_PROG, OP_SECTOR_ERASE,
          OP_BLOCK32_ERASE, OP_BLOCK64_ERASE: state_r <= ST_ADDR;
          default: state_r <= ST_IGNORE;
        endcase
      end
      else if (popFire)
      begin
        case (state_r)
          ST_ADDR:
          begin
            addr_r    <= addrNxt;
            addrCnt_r <= addrCnt_r + 2'h1;
            if (addrCnt_r == 2'(ADDR_BYTES - 3'h1))
            begin
              addrInfo_r <= addrDecode;
              addrStb_r  <= 1'b1;
              state_r    <= ST_IGNORE;
            end
          end
          ST_STATUS_DATA: state_r <= ST_IGNORE;
          ST_CMD, ST_IGNORE: state_r <= ST_IGNORE;
          default: state_r <= ST_IGNORE;
        endcase
      end
    end
  end

  assign statusOut  = status_r;
  assign addrStrobe = addrStb_r;
  assign addrInfo   = addrInfo_r;
  assign rxOverflow = overflow_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_status_try;
    popFire && !popByte.first && state_r == ST_STATUS_DATA && status_r.writeEnableLatch;
  endsequence

  property p_locked_ignored;
    @(posedge clk_sys) disable iff (!rstN)
    s_status_try ##0 statusLocked |=> $stable(status_r[7:2]) && !status_r.busyFlag;
  endproperty
  a_locked_ignored: assert property (p_locked_ignored)
    else $error("status write taken while locked");

  property p_write_sets_busy;
    @(posedge clk_sys) disable iff (!rstN)
    s_status_try ##0 !statusLocked |=> status_r.busyFlag
      && status_r[7:2] == $past(popByte.data[7:2]);
  endproperty
  a_write_sets_busy: assert property (p_write_sets_busy)
    else $error("status write did not start a busy cycle");

  property p_quad_frees_wp;
    @(posedge clk_sys) disable iff (!rstN)
    s_status_try ##0 (status_r.quadLaneEnable && !wpSync_r) |=> status_r.busyFlag;
  endproperty
  a_quad_frees_wp: assert property (p_quad_frees_wp)
    else $error("write-protect still acting with quad enabled");

  property p_busy_holds;
    @(posedge clk_sys) disable iff (!rstN)
    $rose(status_r.busyFlag) |-> status_r.busyFlag[*8] ##[1:1000] !status_r.busyFlag;
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("busy cycle too short or never ends");

  property p_busy_end_clears_latch;
    @(posedge clk_sys) disable iff (!rstN)
    $fell(status_r.busyFlag) |-> !status_r.writeEnableLatch;
  endproperty
  a_busy_end_clears_latch: assert property (p_busy_end_clears_latch)
    else $error("write enable latch left set after write");

  property p_reset_default;
    @(posedge clk_sys) disable iff (!rstN)
    $rose(rstS1_r) |-> ##1 status_r == status_t'(STATUS_RESET);
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("status not zero after reset");

  property p_block_map;
    @(posedge clk_sys) disable iff (!rstN)
    addrStrobe |-> addrInfo.block32 == addrInfo.sector[11:3]
      && addrInfo.block64 == (Has64kBlocks ? addrInfo.sector[11:4] : 8'h00);
  endproperty
  a_block_map: assert property (p_block_map)
    else $error("block index disagrees with sector index");

  property p_range;
    @(posedge clk_sys) disable iff (!rstN)
    addrStrobe |-> addrInfo.inRange == ({addrInfo.sector, addrInfo.offset} <= TopAddr);
  endproperty
  a_range: assert property (p_range)
    else $error("address range flag wrong");

  property p_quiet_deselected;
    @(posedge sck) disable iff (!rst_n)
    cs_n |-> !lane1Oe && !lane2Oe && !lane3Oe;
  endproperty
  a_quiet_deselected: assert property (p_quiet_deselected)
    else $error("output driven while deselected");

  property p_drive_only_status;
    @(negedge sck) disable iff (!rst_n)
    lane1Oe |-> cmd_r == OP_READ_STATUS && byteIdx_r != 3'h0;
  endproperty
  a_drive_only_status: assert property (p_drive_only_status)
    else $error("output lane driven outside a status read");

endmodule

/* spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
  output logic      sck,
  output logic      cs_n,
  output logic      lane0,
  input  wire logic lane1Out,
  input  wire logic lane1Oe,
  output logic      lane1,
  output logic      lane2,
  output logic      lane3
);
  localparam realtime Half = 62.5;
  logic cpol;

  initial
  begin
    cpol = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    lane0 = 1'b1;
    lane2 = 1'b1;
    lane3 = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // undriven lane shows the inverse, so a stale bit never reads right
  assign lane1 = lane1Oe ? lane1Out : ~lane1Out;

  task setMode(input logic m);
    cpol = m;
    sck = m;
  endtask

  task setWp(input logic v);
    lane2 = v;
  endtask

  task start();
    #3.1;
    cs_n = 1'b0;
    #Half;
  endtask

  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sck = 1'b0;
      lane0 = tx[i];
      #Half;
      sck = 1'b1;
      rx[i] = lane1;
      #Half;
    end
  endtask

  task stop();
    if (!cpol)
    begin
      sck = 1'b0;
      #Half;
    end
    cs_n = 1'b1;
    lane0 = ~lane0;
    #(4 * Half);
  endtask
endmodule

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import flash_pkg::*;
  localparam logic [23:0] ADDRS [6] = '{24'h000FFF, 24'h012345, 24'h06FFFF,
                                        24'h070000, 24'h07FFFF, 24'h080000};
  localparam logic [7:0]  OPS [6]   = '{OP_READ_DATA, OP_PAGE_PROG, OP_QUAD_PROG,
                                        OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE};
  logic       clk_sys;
  logic       rst_n;
  logic       sck, cs_n, lane0, lane1, lane2, lane3, lane1Out, lane1Oe;
  status_t    statusOut;
  addr_info_t addrInfo;
  logic       addrStrobe, rxOverflow;
  int         n_fail, checks, busyCnt, nStrobe;
  logic [7:0] r;

  flash_spi_front DUT (.clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .lane0In(lane0), .lane0Out(), .lane0Oe(), .lane1In(lane1), .lane1Out(lane1Out),
    .lane1Oe(lane1Oe), .lane2In(lane2), .lane2Out(), .lane2Oe(), .lane3In(lane3),
    .lane3Out(), .lane3Oe(), .statusOut(statusOut), .addrStrobe(addrStrobe),
    .addrInfo(addrInfo), .rxOverflow(rxOverflow));
  spi_master_model m (.sck(sck), .cs_n(cs_n), .lane0(lane0), .lane1Out(lane1Out),
    .lane1Oe(lane1Oe), .lane1(lane1), .lane2(lane2), .lane3(lane3));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(negedge clk_sys)
  begin
    if (addrStrobe === 1'b1) nStrobe++;
    if (statusOut.busyFlag === 1'b1) busyCnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop();
    if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [42:0] got, input logic [42:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  task timeOut();
    chk(1'b0, 1'b1, "wait ran out");
    report_and_stop();
  endtask

  task waitBusy(input logic lvl);
    int i;
    for (i = 0; i < 3000 && statusOut.busyFlag !== lvl; i++) @(negedge clk_sys);
    if (i == 3000) timeOut();
  endtask

  task cmd(input logic [7:0] op);
    m.start();
    m.xfer(op, r);
    m.stop();
  endtask

  task writeStatus(input logic [7:0] v);
    cmd(OP_WRITE_ENABLE);
    m.start();
    m.xfer(OP_STATUS_WRITE_CMD, r);
    m.xfer(v, r);
    m.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task t_read(input logic [7:0] exp);
    m.start();
    m.xfer(OP_READ_STATUS, r);
    m.xfer(8'h00, r);
    m.stop();
    chk(r, exp, "status read bits");
    chk(lane1Oe, 1'b0, "output lane driven while deselected");
  endtask

  // accepted write; a stuffed frame meanwhile must overflow the stalled queue
  task doWrite(input logic [7:0] v);
    busyCnt = 0;
    writeStatus(v);
    waitBusy(1'b1);
    chk(statusOut, {v[7:2], 2'b11}, "status while busy");
    m.start();
    repeat (8) m.xfer(8'h00, r);
    m.stop();
    chk(rxOverflow, 1'b1, "overflow flag");
    waitBusy(1'b0);
    chk(busyCnt, BUSY_CYCLES, "busy length");
    chk(statusOut, {v[7:2], 2'b00}, "status after write");
  endtask

  task t_lock();
    m.setWp(1'b0);
    writeStatus(8'h00);
    repeat (200) @(negedge clk_sys);
    chk(statusOut[7:2], 6'h20, "locked status changed");
    m.setWp(1'b1);
  endtask

  task t_addr();
    addr_info_t e;
    int s;
    int j;
    for (int i = 0; i < 6; i++)
    begin
      s = nStrobe;
      m.start();
      m.xfer(OPS[i], r);
      m.xfer(ADDRS[i][23:16], r);
      m.xfer(ADDRS[i][15:8], r);
      m.xfer(ADDRS[i][7:0], r);
      m.stop();
      for (j = 0; j < 200 && nStrobe == s; j++) @(negedge clk_sys);
      if (nStrobe != s + 1) timeOut();
      e.sector = ADDRS[i][23:12];
      e.offset = ADDRS[i][11:0];
      e.block32 = ADDRS[i][23:15];
      e.block64 = ADDRS[i][23:16];
      e.inRange = ADDRS[i] <= TOP_ADDR_4M;
      // one protect step covers the top 64 KB and everything above it
      e.isProtected = ADDRS[i] >= 24'h070000;
      chk(addrInfo, e, "address decode");
    end
  endtask

  // four bytes fill the queue while busy without loss, then run in order
  task t_fifo();
    addr_info_t e;
    int s;
    int j;
    s = nStrobe;
    writeStatus(8'h00);
    waitBusy(1'b1);
    m.start();
    m.xfer(OP_READ_DATA, r);
    m.xfer(8'h01, r);
    m.xfer(8'h23, r);
    m.xfer(8'h45, r);
    m.stop();
    chk(statusOut.busyFlag, 1'b1, "queue frame outlasted busy");
    chk(nStrobe, s, "byte taken while busy");
    chk(rxOverflow, 1'b0, "queue of four overflowed");
    waitBusy(1'b0);
    for (j = 0; j < 200 && nStrobe == s; j++) @(negedge clk_sys);
    if (nStrobe != s + 1) timeOut();
    e.sector = 12'h012;
    e.offset = 12'h345;
    e.block32 = 9'h002;
    e.block64 = 8'h01;
    e.inRange = 1'b1;
    e.isProtected = 1'b0;
    chk(addrInfo, e, "queued address decode");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_fail = 0;
    checks = 0;
    busyCnt = 0;
    nStrobe = 0;
    rst_n = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(statusOut, STATUS_RESET, "status reset");
    chk({addrStrobe, rxOverflow, lane1Oe}, 3'h0, "outputs at reset");
    t_read(8'h00);
    t_fifo();
    doWrite(8'h80);
    m.setMode(1'b1);
    t_read(8'h80);
    t_lock();
    doWrite(8'h04);
    t_addr();
    doWrite(8'hC0);
    m.setWp(1'b0);
    doWrite(8'h00);
    m.setWp(1'b1);
    report_and_stop();
  end
endmodule
